// ### include/kse_pkg.sv
// constants and carrier types for the keyboard response and scan encoder
package kse_pkg;
  // ================= response bytes
  localparam logic [7:0] KSE_ACK = 8'hfa;
  localparam logic [7:0] KSE_POST_PASS = 8'haa;
  localparam logic [7:0] KSE_POST_FAIL = 8'hfc;
  localparam logic [7:0] KSE_ECHO = 8'hee;
  localparam logic [7:0] KSE_RESEND = 8'hfe;
  localparam logic [7:0] KSE_ERR_SET1 = 8'hff;
  localparam logic [7:0] KSE_ERR_SET23 = 8'h00;
  // identification value, arbitrary neutral value
  localparam logic [15:0] KSE_ID_VALUE = 16'h5a01;
  // ================= host command bytes
  localparam logic [7:0] KSE_CMD_ECHO = 8'hee;
  localparam logic [7:0] KSE_CMD_RESEND = 8'hfe;
  localparam logic [7:0] KSE_CMD_READ_ID = 8'hf2;
  localparam logic [7:0] KSE_CMD_SEL_SET = 8'hf0;
  localparam logic [7:0] KSE_CMD_LOWEST = 8'hed;
  localparam logic [7:0] KSE_OPT_QUERY = 8'h00;
  localparam logic [7:0] KSE_OPT_MAX = 8'h03;
  // ================= scan code sets
  localparam logic [1:0] KSE_SET1 = 2'h1;
  localparam logic [1:0] KSE_SET2 = 2'h2;
  localparam logic [1:0] KSE_SET3 = 2'h3;
  localparam logic [1:0] KSE_SET_DEFAULT = KSE_SET2;
  localparam logic [7:0] KSE_EXT_PREFIX = 8'he0;
  localparam logic [7:0] KSE_BRK_PREFIX = 8'hf0;
  localparam logic [7:0] KSE_BRK_BIT = 8'h80;
  localparam logic [7:0] KSE_LSH_MAKE = 8'h2a;
  localparam logic [7:0] KSE_RSH_MAKE = 8'h36;
  // ================= output buffer
  localparam int KSE_FIFO_AW = 4;
  localparam logic [KSE_FIFO_AW:0] KSE_FIFO_DEPTH = 5'h10;
  localparam logic [1:0] KSE_RESP_ACK_ONLY = 2'h1;
  localparam logic [1:0] KSE_RESP_ACK_ID = 2'h3;
  localparam logic [1:0] KSE_RESP_TWO = 2'h2;

  // command byte from the link receiver
  typedef struct packed {
    logic valid;
    logic parity_err;
    logic [7:0] data;
  } kse_cmd_t;

  // key event from the matrix scanner
  typedef struct packed {
    logic valid;
    logic make;      // 1 press or repeat, 0 release
    logic err;       // switch closure could not be identified
    logic [6:0] num; // key number
    logic ext2;      // set 2/3 code needs the extended prefix
    logic [7:0] code2; // set 2/3 make code
  } kse_key_t;

  // shift and lock state
  typedef struct packed {
    logic lshift;
    logic rshift;
    logic numlock;
  } kse_mods_t;

  // set 1 lookup result
  typedef struct packed {
    logic found;
    logic ext;
    logic nav;   // shift dependent group
    logic navnum; // also reacts to num lock
    logic [7:0] code;
  } kse_s1_t;
endpackage

// ### rtl/kse_encoder.sv
// keyboard response and scan code encoder with output buffer
`timescale 1ns/1ns
module kse_encoder
  import kse_pkg::*;
(
  input wire logic sys_clk, // 25 MHz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire kse_pkg::kse_cmd_t cmd, // host byte from receiver
  output logic cmd_ready, // command byte taken
  input wire kse_pkg::kse_key_t key, // key event
  output logic key_ready, // key event taken
  input wire kse_pkg::kse_mods_t mods, // shift and lock state
  input wire logic post_done, // self-test finished, pulse
  input wire logic post_pass, // self-test result with post_done
  output logic [7:0] tx_data, // head of output buffer
  output logic tx_valid, // buffer not empty
  input wire logic tx_ready, // link took tx_data
  input wire logic tx_abort, // host interrupted current byte
  output logic [1:0] scan_set, // active scan code set
  output logic scan_enable // matrix scanning allowed
);
  import kse_pkg::*;

  // ==========================================================
  // set 1 base table
  function automatic kse_s1_t s1_lookup(input logic [6:0] n);
    kse_s1_t r;
    logic [7:0] k;
    r = '0;
    k = {1'b0, n};
    r.found = 1'b1;
    case (n)
      7'd1: r.code = 8'h29;
      7'd29, 7'd42: r.code = 8'h2b;
      7'd30: r.code = 8'h3a;
      7'd43: r.code = 8'h1c;
      7'd44: r.code = 8'h2a;
      7'd45: r.code = 8'h56;
      7'd57: r.code = 8'h36;
      7'd58: r.code = 8'h1d;
      7'd60: r.code = 8'h38;
      7'd61: r.code = 8'h39;
      7'd90: r.code = 8'h45;
      7'd91: r.code = 8'h47;
      7'd92: r.code = 8'h4b;
      7'd93: r.code = 8'h4f;
      7'd96: r.code = 8'h48;
      7'd97: r.code = 8'h4c;
      7'd98: r.code = 8'h50;
      7'd99: r.code = 8'h52;
      7'd100: r.code = 8'h37;
      7'd101: r.code = 8'h49;
      7'd102: r.code = 8'h4d;
      7'd103: r.code = 8'h51;
      7'd104: r.code = 8'h53;
      7'd105: r.code = 8'h4a;
      7'd106: r.code = 8'h4e;
      7'd110: r.code = 8'h01;
      7'd122: r.code = 8'h57;
      7'd123: r.code = 8'h58;
      7'd125: r.code = 8'h46;
      7'd62: begin r.ext = 1'b1; r.code = 8'h38; end
      7'd64: begin r.ext = 1'b1; r.code = 8'h1d; end
      7'd108: begin r.ext = 1'b1; r.code = 8'h1c; end
      7'd95: begin r.ext = 1'b1; r.nav = 1'b1; r.code = 8'h35; end
      7'd75: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h52; end
      7'd76: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h53; end
      7'd79: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h4b; end
      7'd80: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h47; end
      7'd81: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h4f; end
      7'd83: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h48; end
      7'd84: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h50; end
      7'd85: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h49; end
      7'd86: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h51; end
      7'd89: begin r.ext = 1'b1; r.nav = 1'b1; r.navnum = 1'b1; r.code = 8'h4d; end
      default:
      begin
        // runs of consecutive codes
        if (n >= 7'd2 && n <= 7'd13)
          r.code = k;
        else if (n >= 7'd15 && n <= 7'd28)
          r.code = k - 8'h01;
        else if (n >= 7'd31 && n <= 7'd41)
          r.code = k - 8'h01;
        else if (n >= 7'd46 && n <= 7'd55)
          r.code = k - 8'h02;
        else if (n >= 7'd112 && n <= 7'd121)
          r.code = k - 8'h35;
        else
          r.found = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // control state
  logic [1:0] set_r;
  logic halted_r;
  logic optw_r;
  logic [7:0] last_tx_r;
  logic [7:0] resp_q [0:2];
  logic [1:0] resp_n;
  logic [7:0] seq_q [0:3];
  logic [2:0] seq_n;
  logic cmd_take;
  logic key_take;
  logic flush;

  assign scan_set = set_r;
  assign scan_enable = !halted_r && !optw_r && resp_n == 2'h0;
  assign cmd_ready = resp_n == 2'h0 && seq_n == 3'h0 && !post_done;
  assign cmd_take = cmd.valid && cmd_ready;
  assign key_ready = scan_enable && seq_n == 3'h0 && !cmd.valid && !post_done;
  assign key_take = key.valid && key_ready;
  assign flush = cmd_take && !cmd.parity_err && !optw_r && cmd.data == KSE_CMD_SEL_SET;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      set_r <= KSE_SET_DEFAULT;
      optw_r <= 1'b0;
      halted_r <= 1'b0;
    end
    else if (post_done)
      halted_r <= !post_pass;
    else if (cmd_take)
    begin
      halted_r <= 1'b0; // host answered
      optw_r <= flush;
      if (optw_r && !cmd.parity_err && cmd.data != KSE_OPT_QUERY && cmd.data <= KSE_OPT_MAX)
        set_r <= cmd.data[1:0];
    end
  end

  // ==========================================================
  // response queue, emptied one byte per cycle into the buffer
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      resp_n <= 2'h0;
    else if (post_done)
    begin
      resp_q[0] <= post_pass ? KSE_POST_PASS : KSE_POST_FAIL;
      resp_n <= KSE_RESP_ACK_ONLY;
    end
    else if (cmd_take)
    begin
      resp_n <= KSE_RESP_ACK_ONLY;
      resp_q[0] <= KSE_ACK;
      if (cmd.parity_err)
        resp_q[0] <= KSE_RESEND;
      else if (optw_r)
      begin
        if (cmd.data > KSE_OPT_MAX)
          resp_q[0] <= KSE_RESEND;
        else if (cmd.data == KSE_OPT_QUERY)
        begin
          resp_q[1] <= {6'h00, set_r};
          resp_n <= KSE_RESP_TWO;
        end
      end
      else if (cmd.data == KSE_CMD_ECHO)
        resp_q[0] <= KSE_ECHO;
      else if (cmd.data == KSE_CMD_RESEND)
        resp_q[0] <= last_tx_r;
      else if (cmd.data == KSE_CMD_READ_ID)
      begin
        resp_q[1] <= KSE_ID_VALUE[7:0];
        resp_q[2] <= KSE_ID_VALUE[15:8];
        resp_n <= KSE_RESP_ACK_ID;
      end
      else if (cmd.data < KSE_CMD_LOWEST)
        resp_q[0] <= KSE_RESEND;
    end
    else if (resp_n != 2'h0)
    begin
      resp_q[0] <= resp_q[1];
      resp_q[1] <= resp_q[2];
      resp_n <= resp_n - 2'h1;
    end
  end

  // ==========================================================
  // scan code sequence builder
  kse_s1_t s1;
  logic [7:0] b [0:3];
  logic [2:0] blen;
  logic [7:0] sh_mk;
  logic [7:0] sh_brk;
  logic shift_any;
  logic [7:0] err_code;

  assign s1 = s1_lookup(key.num);
  assign shift_any = mods.lshift || mods.rshift;
  assign sh_mk = (mods.rshift && !mods.lshift) ? KSE_RSH_MAKE : KSE_LSH_MAKE;
  assign sh_brk = sh_mk | KSE_BRK_BIT;
  assign err_code = set_r == KSE_SET1 ? KSE_ERR_SET1 : KSE_ERR_SET23;

  always_comb
  begin
    b[0] = err_code;
    b[1] = 8'h00;
    b[2] = 8'h00;
    b[3] = 8'h00;
    blen = 3'h1;
    if (key.err)
      b[0] = err_code;
    else if (set_r != KSE_SET1)
    begin
      // set 3 break shares the set 2 form
      b[0] = key.ext2 ? KSE_EXT_PREFIX : KSE_BRK_PREFIX;
      b[1] = key.ext2 ? KSE_BRK_PREFIX : key.code2;
      b[2] = key.code2;
      blen = {2'b00, key.ext2} + (key.make ? 3'h1 : 3'h2);
      if (key.make)
        b[key.ext2 ? 1 : 0] = key.code2;
    end
    else if (s1.found)
    begin
      // repeats arrive as make events and reuse the base make code
      b[0] = key.make ? s1.code : (s1.code | KSE_BRK_BIT);
      if (s1.ext)
      begin
        b[0] = KSE_EXT_PREFIX;
        b[1] = key.make ? s1.code : (s1.code | KSE_BRK_BIT);
        blen = 3'h2;
        if (s1.nav && shift_any && !(s1.navnum && mods.numlock))
        begin
          blen = 3'h4;
          if (key.make)
          begin
            b[1] = sh_brk;
            b[2] = KSE_EXT_PREFIX;
            b[3] = s1.code;
          end
          else
          begin
            b[2] = KSE_EXT_PREFIX;
            b[3] = sh_mk;
          end
        end
        else if (s1.navnum && mods.numlock && !shift_any)
        begin
          blen = 3'h4;
          b[2] = KSE_EXT_PREFIX;
          if (key.make)
          begin
            b[1] = KSE_LSH_MAKE;
            b[3] = s1.code;
          end
          else
            b[3] = KSE_LSH_MAKE | KSE_BRK_BIT;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      seq_n <= 3'h0;
    else if (key_take)
    begin
      for (int i = 0; i < 4; i++)
        seq_q[i] <= b[i];
      seq_n <= blen;
    end
    else if (seq_n != 3'h0 && resp_n == 2'h0)
    begin
      for (int i = 0; i < 3; i++)
        seq_q[i] <= seq_q[i + 1];
      seq_n <= seq_n - 3'h1;
    end
  end

  // ==========================================================
  // output buffer; pushes are never refused, a full buffer overruns
  logic [7:0] mem [0:KSE_FIFO_DEPTH - 1];
  logic [KSE_FIFO_AW - 1:0] rp_r;
  logic [KSE_FIFO_AW - 1:0] wp_r;
  logic [KSE_FIFO_AW:0] cnt_r;
  logic ovr_r;
  logic push;
  logic [7:0] push_b;
  logic pop;
  logic full;

  assign push = resp_n != 2'h0 || seq_n != 3'h0;
  assign push_b = resp_n != 2'h0 ? resp_q[0] : seq_q[0];
  assign tx_valid = cnt_r != '0;
  assign tx_data = mem[rp_r];
  // an interrupted acknowledge is thrown away, anything else is resent
  assign pop = tx_valid && (tx_ready || (tx_abort && tx_data == KSE_ACK));
  assign full = cnt_r == KSE_FIFO_DEPTH;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || flush)
    begin
      rp_r <= '0;
      wp_r <= '0;
      cnt_r <= '0;
      ovr_r <= 1'b0;
    end
    else
    begin
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push && (!full || pop))
      begin
        mem[wp_r] <= push_b;
        wp_r <= wp_r + 1'b1;
      end
      else if (push && !ovr_r)
      begin
        mem[wp_r - 1'b1] <= err_code;
        ovr_r <= 1'b1;
      end
      if (pop)
        ovr_r <= 1'b0;
      cnt_r <= cnt_r + {4'h0, push && (!full || pop)} - {4'h0, pop};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      last_tx_r <= KSE_RESEND;
    else if (tx_valid && tx_ready)
      last_tx_r <= tx_data;
  end
endmodule

// ### tb/kse_encoder_properties.sv
// port assertions and covers for the keyboard encoder
`timescale 1ns/1ns
module kse_encoder_properties
  import kse_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire kse_pkg::kse_cmd_t cmd, // host byte
  input wire logic cmd_ready, // byte taken
  input wire kse_pkg::kse_key_t key, // key event
  input wire logic key_ready, // event taken
  input wire kse_pkg::kse_mods_t mods, // modifiers
  input wire logic post_done, // self-test end
  input wire logic post_pass, // self-test result
  input wire logic [7:0] tx_data, // buffer head
  input wire logic tx_valid, // buffer not empty
  input wire logic tx_ready, // pop
  input wire logic tx_abort, // host interrupt
  input wire logic [1:0] scan_set, // active set
  input wire logic scan_enable // scanning allowed
);
  // ==========
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic take;
  // only an empty buffer makes the answer the head two edges later
  assign take = cmd.valid && cmd_ready && !tx_valid;
  chk_echo_reply: assert property (
    take && !cmd.parity_err && cmd.data == KSE_CMD_ECHO && scan_enable
    |-> ##2 tx_valid && tx_data == KSE_ECHO) else $error("echo reply wrong");
  chk_resend_reply: assert property (
    take && cmd.parity_err |-> ##2 tx_valid && tx_data == KSE_RESEND)
    else $error("resend reply wrong");
  chk_post_pass: assert property (
    post_done && post_pass && !tx_valid |-> ##2 tx_valid && tx_data == KSE_POST_PASS)
    else $error("completion byte missing");
  chk_post_halt: assert property (
    post_done && !post_pass |-> ##2 !scan_enable && !key_ready)
    else $error("scanning not halted");
  chk_reset_set: assert property (
    $past(sys_rst) |-> scan_set == KSE_SET_DEFAULT && !tx_valid)
    else $error("reset state wrong");
  chk_key_gate: assert property (
    !scan_enable |-> !key_ready) else $error("key taken while suspended");
  chk_cmd_suspend: assert property (
    cmd.valid && cmd_ready |=> !scan_enable && !key_ready)
    else $error("scanning not suspended after command");
  chk_id_suspend: assert property (
    take && !cmd.parity_err && cmd.data == KSE_CMD_READ_ID && scan_enable
    |-> ##1 !key_ready ##1 !key_ready && tx_data == KSE_ACK)
    else $error("read id sequence wrong");
  chk_head_hold: assert property (
    tx_valid && !tx_ready && !tx_abort && !cmd.valid && !$past(cmd.valid)
    |=> tx_valid && $stable(tx_data)) else $error("head changed without pop");
  chk_abort_keep: assert property (
    tx_valid && tx_abort && !tx_ready && tx_data != KSE_ACK && !cmd.valid
    |=> tx_valid) else $error("non ack byte dropped");
  cover property (post_done && !post_pass);
  cover property (tx_abort && tx_valid);
  cover property (key.valid && key_ready && scan_set == KSE_SET1);
endmodule
bind kse_encoder kse_encoder_properties u_chk (.sys_clk, .sys_rst, .cmd, .cmd_ready, .key,
  .key_ready, .mods, .post_done, .post_pass, .tx_data, .tx_valid, .tx_ready, .tx_abort,
  .scan_set, .scan_enable);

// ### tb/kse_host_model.sv
// host controller model that collects bytes from the encoder
`timescale 1ns/1ns
module kse_host_model
  import kse_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic post_done, // self-test ended, result byte expected next
  input wire logic [7:0] tx_data, // byte offered
  input wire logic tx_valid, // byte present
  input wire logic stall, // hold off taking bytes
  output logic tx_ready, // byte taken
  output logic kbd_failed // self-test result not completion
);
  // ==========
  // receiver
  logic [7:0] got[$];
  logic first_r;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tx_ready <= 1'b0;
      first_r <= 1'b1;
      kbd_failed <= 1'b0;
    end
    else
    begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready)
      begin
        got.push_back(tx_data);
        first_r <= 1'b0;
        // any other first byte means a dead keyboard
        if (first_r)
          kbd_failed <= (tx_data !== KSE_POST_PASS);
      end
      // every self-test makes the next byte a result byte again
      if (post_done)
        first_r <= 1'b1;
    end
  end
endmodule

// ### tb/kse_encoder_tb.sv
// self-checking bench for the keyboard response and scan encoder
`timescale 1ns/1ns
module kse_encoder_tb;
  import kse_pkg::*;
  logic sys_clk, sys_rst, post_done, post_pass, tx_abort, stall;
  logic cmd_ready, key_ready, tx_valid, tx_ready, scan_enable, kbd_failed;
  logic [7:0] tx_data;
  logic [1:0] scan_set;
  logic ext_sel;
  kse_cmd_t cmd;
  kse_key_t key;
  kse_mods_t mods;
  int bad_count, num_checks;
  kse_encoder dut (.sys_clk, .sys_rst, .cmd, .cmd_ready, .key, .key_ready, .mods, .post_done,
    .post_pass, .tx_data, .tx_valid, .tx_ready, .tx_abort, .scan_set, .scan_enable);
  kse_host_model host (.sys_clk, .sys_rst, .post_done, .tx_data, .tx_valid, .stall, .tx_ready,
    .kbd_failed);
  // ==========
  // helpers
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic send_cmd(logic [7:0] d, logic pe);
    @(posedge sys_clk);
    cmd <= '{1'b1, pe, d};
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd <= '0;
  endtask
  task automatic send_key(logic mk, logic er, logic [6:0] n, logic [7:0] c2);
    @(posedge sys_clk);
    key <= '{1'b1, mk, er, n, ext_sel, c2};
    do @(posedge sys_clk); while (key_ready !== 1'b1);
    key <= '0;
  endtask
  task automatic pulse_post(logic p);
    @(posedge sys_clk);
    post_done <= 1'b1;
    post_pass <= p;
    @(posedge sys_clk);
    post_done <= 1'b0;
  endtask
  task automatic expect_bytes(logic [7:0] e[$]);
    int k;
    k = 0;
    while (host.got.size() < e.size() && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    // a few extra cycles so that surplus bytes show up too
    tick(3);
    #5;
    check(16'(host.got.size()), 16'(e.size()));
    foreach (e[i])
      check(host.got[i], e[i]);
    host.got.delete();
  endtask
  // ==========
  // scenarios
  task automatic t_post();
    check(scan_set, KSE_SET_DEFAULT);
    pulse_post(1'b1);
    expect_bytes('{KSE_POST_PASS});
    check(kbd_failed, 1'b0);
    pulse_post(1'b0);
    expect_bytes('{KSE_POST_FAIL});
    check(scan_enable, 1'b0);
    check(kbd_failed, 1'b1);
    send_cmd(KSE_CMD_ECHO, 1'b0);
    expect_bytes('{KSE_ECHO});
    check(scan_enable, 1'b1);
    $display("test post finished");
  endtask
  task automatic t_cmds();
    send_cmd(KSE_CMD_ECHO, 1'b0);
    expect_bytes('{KSE_ECHO});
    send_cmd(8'hf4, 1'b0);
    expect_bytes('{KSE_ACK});
    send_cmd(8'hec, 1'b0);
    expect_bytes('{KSE_RESEND});
    send_cmd(8'hf4, 1'b1);
    expect_bytes('{KSE_RESEND});
    send_cmd(KSE_CMD_READ_ID, 1'b0);
    expect_bytes('{KSE_ACK, KSE_ID_VALUE[7:0], KSE_ID_VALUE[15:8]});
    check(scan_enable, 1'b1);
    send_cmd(KSE_CMD_RESEND, 1'b0);
    expect_bytes('{KSE_ID_VALUE[15:8]});
    $display("test commands finished");
  endtask
  task automatic t_keys();
    send_key(1'b1, 1'b0, 7'd31, 8'h1c);
    send_key(1'b0, 1'b0, 7'd31, 8'h1c);
    expect_bytes('{8'h1c, KSE_BRK_PREFIX, 8'h1c});
    send_key(1'b1, 1'b1, 7'd31, 8'h1c);
    expect_bytes('{KSE_ERR_SET23});
    ext_sel = 1'b1;
    send_key(1'b1, 1'b0, 7'd62, 8'h11);
    send_key(1'b0, 1'b0, 7'd62, 8'h11);
    ext_sel = 1'b0;
    expect_bytes('{KSE_EXT_PREFIX, 8'h11, KSE_EXT_PREFIX, KSE_BRK_PREFIX, 8'h11});
    send_cmd(KSE_CMD_SEL_SET, 1'b0);
    #5 check(scan_enable, 1'b0);
    send_cmd(8'h01, 1'b0);
    expect_bytes('{KSE_ACK, KSE_ACK});
    send_cmd(KSE_CMD_SEL_SET, 1'b0);
    send_cmd(KSE_OPT_QUERY, 1'b0);
    expect_bytes('{KSE_ACK, KSE_ACK, 8'h01});
    send_key(1'b1, 1'b0, 7'd1, 8'h0e);
    send_key(1'b1, 1'b0, 7'd1, 8'h0e);
    send_key(1'b0, 1'b0, 7'd1, 8'h0e);
    expect_bytes('{8'h29, 8'h29, 8'ha9});
    send_key(1'b1, 1'b0, 7'd62, 8'h11);
    expect_bytes('{KSE_EXT_PREFIX, 8'h38});
    send_key(1'b1, 1'b0, 7'd112, 8'h05);
    expect_bytes('{8'h3b});
    @(posedge sys_clk);
    mods <= '{1'b0, 1'b1, 1'b0};
    send_key(1'b1, 1'b0, 7'd75, 8'h70);
    send_key(1'b0, 1'b0, 7'd75, 8'h70);
    expect_bytes('{8'he0, 8'hb6, 8'he0, 8'h52, 8'he0, 8'hd2, 8'he0, 8'h36});
    @(posedge sys_clk);
    mods <= '{1'b0, 1'b0, 1'b1};
    send_key(1'b1, 1'b0, 7'd75, 8'h70);
    send_key(1'b0, 1'b0, 7'd75, 8'h70);
    expect_bytes('{8'he0, 8'h2a, 8'he0, 8'h52, 8'he0, 8'hd2, 8'he0, 8'haa});
    @(posedge sys_clk);
    mods <= '0;
    send_key(1'b1, 1'b1, 7'd1, 8'h0e);
    expect_bytes('{KSE_ERR_SET1});
    $display("test keys finished");
  endtask
  task automatic t_overrun();
    logic [7:0] e[$];
    @(posedge sys_clk);
    stall <= 1'b1;
    repeat (17) send_key(1'b1, 1'b0, 7'd1, 8'h0e);
    repeat (15) e.push_back(8'h29);
    e.push_back(KSE_ERR_SET1);
    tick(3);
    stall <= 1'b0;
    expect_bytes(e);
    $display("test overrun finished");
  endtask
  task automatic t_abort();
    @(posedge sys_clk);
    stall <= 1'b1;
    send_cmd(KSE_CMD_ECHO, 1'b0);
    tick(3);
    tx_abort <= 1'b1;
    @(posedge sys_clk);
    tx_abort <= 1'b0;
    #5 check(tx_data, KSE_ECHO);
    @(posedge sys_clk);
    stall <= 1'b0;
    expect_bytes('{KSE_ECHO});
    @(posedge sys_clk);
    stall <= 1'b1;
    send_cmd(8'hf4, 1'b0);
    tick(3);
    tx_abort <= 1'b1;
    @(posedge sys_clk);
    tx_abort <= 1'b0;
    #5 check(tx_valid, 1'b0);
    @(posedge sys_clk);
    stall <= 1'b0;
    send_cmd(KSE_CMD_ECHO, 1'b0);
    expect_bytes('{KSE_ECHO});
    $display("test abort finished");
  endtask
  task automatic t_set3();
    send_cmd(KSE_CMD_SEL_SET, 1'b0);
    send_cmd(8'h03, 1'b0);
    expect_bytes('{KSE_ACK, KSE_ACK});
    check(scan_set, KSE_SET3);
    send_cmd(KSE_CMD_SEL_SET, 1'b0);
    send_cmd(KSE_OPT_QUERY, 1'b0);
    expect_bytes('{KSE_ACK, KSE_ACK, 8'h03});
    send_key(1'b1, 1'b1, 7'd1, 8'h0e);
    expect_bytes('{KSE_ERR_SET23});
    $display("test set three finished");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    sys_rst = 1'b1;
    cmd = '0;
    key = '0;
    mods = '0;
    post_done = 1'b0;
    post_pass = 1'b0;
    tx_abort = 1'b0;
    stall = 1'b0;
    ext_sel = 1'b0;
    bad_count = 0;
    num_checks = 0;
    tick(12);
    sys_rst <= 1'b0;
    t_post();
    t_cmds();
    t_keys();
    t_overrun();
    t_abort();
    t_set3();
    close_out();
  end
  // the scenarios need a few hundred cycles; this allows ten thousand
  initial
  begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule
